/* design/maec_pkg.sv */
// Constants and types shared by the alert enable and configuration block
package maec_pkg;
   // Register offsets
   localparam logic [7:0] OFS_SPECIAL_FN  = 8'h7c;
   localparam logic [7:0] OFS_VOLT_EN     = 8'h7e;
   localparam logic [7:0] OFS_DEV_CFG     = 8'h7f;
   localparam logic [7:0] OFS_FAN_EN      = 8'h80;
   localparam logic [7:0] OFS_ASSOC       = 8'h81;
   localparam logic [7:0] OFS_THERM_EN    = 8'h82;
   // Reset values
   localparam logic [7:0] RST_SPECIAL_FN  = 8'h40;
   localparam logic [7:0] RST_VOLT_EN     = 8'hec;
   localparam logic [7:0] RST_DEV_CFG     = 8'h10;
   localparam logic [7:0] RST_FAN_EN      = 8'h1e;
   localparam logic [7:0] RST_ASSOC       = 8'ha4;
   localparam logic [7:0] RST_THERM_EN    = 8'h0e;
   // Writable bit masks; reserved bits read zero
   localparam logic [7:0] MSK_SPECIAL_FN  = 8'hff;
   localparam logic [7:0] MSK_VOLT_EN     = 8'hed;
   localparam logic [7:0] MSK_DEV_CFG     = 8'h73;
   localparam logic [7:0] MSK_FAN_EN      = 8'h1f;
   localparam logic [7:0] MSK_ASSOC       = 8'hff;
   localparam logic [7:0] MSK_THERM_EN    = 8'h0f;
   // Field positions
   localparam int BIT_GROUP_EN       = 0;
   localparam int BIT_MASTER_ALERT   = 2;
   localparam int BIT_SENSOR3_ALERT  = 0;
   localparam int BIT_DRIVE2_ALERT   = 1;
   localparam int BIT_THERMAL_VALID  = 3;
   localparam int BIT_SPINUP_SHORTEN = 4;
   localparam int BIT_SOFT_RESET     = 7;
   // Source counts
   localparam int NUM_SENSORS = 4;
   localparam int NUM_DRIVES  = 3;
   localparam logic [1:0]  ASSOC_RESERVED = 2'h3;
   localparam logic [7:0]  DUTY_OFF       = 8'h00;
   localparam logic [15:0] MIN_NEVER      = 16'hffff;
   typedef enum logic [2:0] {
      MAEC_IDLE  = 3'b001,
      MAEC_SOFT  = 3'b010,
      MAEC_LOCK  = 3'b100
   } maec_state_t;
endpackage : maec_pkg

/* design/maec_event_gate.sv */
// Gates raw out-of-limit events with per-source enables into sticky status
`timescale 1ns/1ps
`default_nettype none
module maec_event_gate #(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] events,
   input  wire logic [WIDTH-1:0] enables,
   input  wire logic [WIDTH-1:0] ackBits,
   output logic      [WIDTH-1:0] status
);
   typedef struct packed {
      logic [WIDTH-1:0] stat;
   } maec_gate_t;
   maec_gate_t st_reg;
   maec_gate_t st_next;

   // Set wins over acknowledge so a coincident event is not lost
   always_comb begin
      st_next      = st_reg;
      st_next.stat = (st_reg.stat & ~ackBits) | (events & enables);
      if (clear) begin
         st_next.stat = '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign status = st_reg.stat;
endmodule : maec_event_gate
`default_nettype wire

/* design/maec_fan_qualify.sv */
// Suppresses speed sensor events whose drive is off, disabled or min is FFFFh
`timescale 1ns/1ps
`default_nettype none
module maec_fan_qualify
   import maec_pkg::*;
(
   input  wire logic [7:0]                   assocMap,
   input  wire logic [NUM_DRIVES*8-1:0]      driveDuty,
   input  wire logic [NUM_DRIVES-1:0]        driveEnabled,
   input  wire logic [NUM_SENSORS*16-1:0]    sensorMin,
   input  wire logic [NUM_SENSORS-1:0]       rawEvents,
   output logic      [NUM_SENSORS-1:0]       qualEvents
);
   // Reserved association code counts as no drive, so the event is held off
   function automatic logic drive_active(input logic [1:0] sel,
                                         input logic [NUM_DRIVES*8-1:0] duty,
                                         input logic [NUM_DRIVES-1:0] en);
      logic act;
      act = 1'b0;
      if (sel != ASSOC_RESERVED) begin
         act = en[sel] && (duty[sel*8 +: 8] != DUTY_OFF);
      end
      return act;
   endfunction : drive_active

   always_comb begin
      for (int i = 0; i < NUM_SENSORS; i++) begin
         qualEvents[i] = rawEvents[i]
                       && drive_active(assocMap[2*i +: 2], driveDuty, driveEnabled)
                       && (sensorMin[16*i +: 16] != MIN_NEVER);
      end
   end
endmodule : maec_fan_qualify
`default_nettype wire

/* design/maec_alert_ctrl.sv */
// Alert enable, pin select and configuration registers of the monitor
// Function
// - Lock makes all these registers read only
// - Voltage enables gate voltage status bits
// - Voltage group bit lets voltages pull alert
// - Group enables need master enable too
// - Config bit0 selects sensor three pin alert
// - Config bit1 selects drive two pin alert
// - Config bit3 shows thermal readings valid
// - Config bit4 enables spin-up shortening, default one
// - Config bit7 soft reset, self clearing
// - Fan enables gate sensor status bits
// - Fan group bit lets sensors pull alert
// - Two-bit sensor to drive association fields
// - No sensor status when drive off/disabled
// - Minimum FFFFh never sets sensor status
// - Thermal enables gate temperature status bits
// - Thermal group bit lets temperatures pull alert
// - Special function bit2 is master alert enable
// - Enabled limit violation sets status bit
`timescale 1ns/1ps
`default_nettype none
module maec_alert_ctrl
   import maec_pkg::*;
(
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   // Register port of the serial interface
   input  wire logic                          regWrite,
   input  wire logic                          regRead,
   input  wire logic [7:0]                    regAddr,
   input  wire logic [7:0]                    regWdata,
   output logic      [7:0]                    regRdata,
   output logic                               regRvalid,
   // Lock and monitor state
   input  wire logic                          globalLock,
   input  wire logic                          thermalValid,
   // Raw out-of-limit events
   input  wire logic [7:0]                    voltEvents,
   input  wire logic [maec_pkg::NUM_SENSORS-1:0] fanEvents,
   input  wire logic [2:0]                    thermEvents,
   // Fan drive context
   input  wire logic [maec_pkg::NUM_DRIVES*8-1:0]   driveDuty,
   input  wire logic [maec_pkg::NUM_DRIVES-1:0]     driveEnabled,
   input  wire logic [maec_pkg::NUM_SENSORS*16-1:0] sensorMin,
   // Status acknowledge from the status register owner
   input  wire logic [7:0]                    voltAck,
   input  wire logic [maec_pkg::NUM_SENSORS-1:0] fanAck,
   input  wire logic [2:0]                    thermAck,
   // Outputs
   output logic [7:0]                         voltStatus,
   output logic [maec_pkg::NUM_SENSORS-1:0]   fanStatus,
   output logic [2:0]                         thermStatus,
   output logic                               alert_n,
   output logic                               sensor3PinAlertSelect,
   output logic                               drive2PinAlertSelect,
   output logic                               spinupShortenEnable,
   output logic [7:0]                         sensorDriveAssoc,
   output logic                               softResetPulse
);
   import maec_pkg::*;

   typedef struct packed {
      maec_state_t state;
      logic [7:0]  specialFn;
      logic [7:0]  voltEn;
      logic [7:0]  devCfg;
      logic [7:0]  fanEn;
      logic [7:0]  assoc;
      logic [7:0]  thermEn;
      logic [7:0]  rdata;
      logic        rvalid;
      logic        alertN;
      logic        softPulse;
      logic [7:0]  vStat;
      logic [NUM_SENSORS-1:0] fStat;
      logic [2:0]  tStat;
   } maec_ctrl_t;

   maec_ctrl_t s_reg;
   maec_ctrl_t s_next;

   logic [NUM_SENSORS-1:0] fanQual;
   logic [7:0]             vGate;
   logic [NUM_SENSORS-1:0] fGate;
   logic [2:0]             tGate;
   logic                   clearStat;

   // Masked write keeps reserved bits at zero
   function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
      return d & m;
   endfunction : masked

   // Sensor events qualified by drive state and minimum limit
   maec_fan_qualify u_qual (
      .assocMap     (s_reg.assoc),
      .driveDuty    (driveDuty),
      .driveEnabled (driveEnabled),
      .sensorMin    (sensorMin),
      .rawEvents    (fanEvents),
      .qualEvents   (fanQual)
   );

   assign clearStat = (s_reg.state == MAEC_SOFT);

   // Per-source status gating, one instance per class
   maec_event_gate #(.WIDTH(8)) u_volt (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .clear   (clearStat),
      .events  (voltEvents),
      .enables (s_reg.voltEn & ~8'h01),
      .ackBits (voltAck),
      .status  (vGate)
   );

   maec_event_gate #(.WIDTH(NUM_SENSORS)) u_fan (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .clear   (clearStat),
      .events  (fanQual),
      .enables (s_reg.fanEn[NUM_SENSORS:1]),
      .ackBits (fanAck),
      .status  (fGate)
   );

   maec_event_gate #(.WIDTH(3)) u_therm (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .clear   (clearStat),
      .events  (thermEvents),
      .enables (s_reg.thermEn[3:1]),
      .ackBits (thermAck),
      .status  (tGate)
   );

   // Register access, soft reset sequencing and alert pin
   always_comb begin
      logic writeOk;
      logic groupPend;
      writeOk  = 1'b0;
      groupPend = 1'b0;
      s_next   = s_reg;
      s_next.softPulse = 1'b0;
      s_next.rvalid    = 1'b0;

      case (s_reg.state)
         MAEC_IDLE: begin
            writeOk = regWrite;
            if (globalLock) begin
               s_next.state = MAEC_LOCK;
            end
         end
         MAEC_SOFT: begin
            // One cycle clearing status; defaults and bit 7 were restored on entry
            s_next.state = globalLock ? MAEC_LOCK : MAEC_IDLE;
         end
         MAEC_LOCK: begin
            writeOk = 1'b0;
            if (!globalLock) begin
               s_next.state = MAEC_IDLE;
            end
         end
         default: begin
            s_next.state = MAEC_IDLE;
         end
      endcase

      // Write decode
      if (writeOk && !globalLock) begin
         if (regAddr == OFS_SPECIAL_FN) begin
            s_next.specialFn = masked(regWdata, MSK_SPECIAL_FN);
         end else if (regAddr == OFS_VOLT_EN) begin
            s_next.voltEn = masked(regWdata, MSK_VOLT_EN);
         end else if (regAddr == OFS_DEV_CFG) begin
            s_next.devCfg = masked(regWdata, MSK_DEV_CFG);
            if (regWdata[BIT_SOFT_RESET]) begin
               s_next.state     = MAEC_SOFT;
               s_next.softPulse = 1'b1;
            end
         end else if (regAddr == OFS_FAN_EN) begin
            s_next.fanEn = masked(regWdata, MSK_FAN_EN);
         end else if (regAddr == OFS_ASSOC) begin
            s_next.assoc = regWdata;
         end else if (regAddr == OFS_THERM_EN) begin
            s_next.thermEn = masked(regWdata, MSK_THERM_EN);
         end
      end

      // Soft reset restores every register here to default
      if (s_next.state == MAEC_SOFT) begin
         s_next.specialFn = RST_SPECIAL_FN;
         s_next.voltEn    = RST_VOLT_EN;
         s_next.devCfg    = RST_DEV_CFG;
         s_next.fanEn     = RST_FAN_EN;
         s_next.assoc     = RST_ASSOC;
         s_next.thermEn   = RST_THERM_EN;
      end

      // Read decode; unmapped offsets return zero
      if (regRead) begin
         s_next.rvalid = 1'b1;
         if (regAddr == OFS_SPECIAL_FN) begin
            s_next.rdata = s_reg.specialFn;
         end else if (regAddr == OFS_VOLT_EN) begin
            s_next.rdata = s_reg.voltEn;
         end else if (regAddr == OFS_DEV_CFG) begin
            s_next.rdata = s_reg.devCfg;
            s_next.rdata[BIT_THERMAL_VALID] = thermalValid;
         end else if (regAddr == OFS_FAN_EN) begin
            s_next.rdata = s_reg.fanEn;
         end else if (regAddr == OFS_ASSOC) begin
            s_next.rdata = s_reg.assoc;
         end else if (regAddr == OFS_THERM_EN) begin
            s_next.rdata = s_reg.thermEn;
         end else begin
            s_next.rdata = 8'h00;
         end
      end

      // Group enables feed the pin only under the master enable
      groupPend = (s_reg.voltEn[BIT_GROUP_EN]  && (|vGate))
               || (s_reg.fanEn[BIT_GROUP_EN]   && (|fGate))
               || (s_reg.thermEn[BIT_GROUP_EN] && (|tGate));
      s_next.alertN = !(s_reg.specialFn[BIT_MASTER_ALERT] && groupPend);

      s_next.vStat = vGate;
      s_next.fStat = fGate;
      s_next.tStat = tGate;
   end

   // Control state in one register bank; sticky status sits in the gate instances
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg.state     <= MAEC_IDLE;
         s_reg.specialFn <= RST_SPECIAL_FN;
         s_reg.voltEn    <= RST_VOLT_EN;
         s_reg.devCfg    <= RST_DEV_CFG;
         s_reg.fanEn     <= RST_FAN_EN;
         s_reg.assoc     <= RST_ASSOC;
         s_reg.thermEn   <= RST_THERM_EN;
         s_reg.rdata     <= 8'h00;
         s_reg.rvalid    <= 1'b0;
         s_reg.alertN    <= 1'b1;
         s_reg.softPulse <= 1'b0;
         s_reg.vStat     <= 8'h00;
         s_reg.fStat     <= '0;
         s_reg.tStat     <= 3'h0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs come straight from flip-flops
   assign regRdata              = s_reg.rdata;
   assign regRvalid             = s_reg.rvalid;
   assign alert_n               = s_reg.alertN;
   assign sensor3PinAlertSelect = s_reg.devCfg[BIT_SENSOR3_ALERT];
   assign drive2PinAlertSelect  = s_reg.devCfg[BIT_DRIVE2_ALERT];
   assign spinupShortenEnable   = s_reg.devCfg[BIT_SPINUP_SHORTEN];
   assign sensorDriveAssoc      = s_reg.assoc;
   assign softResetPulse        = s_reg.softPulse;
   assign voltStatus            = s_reg.vStat;
   assign fanStatus             = s_reg.fStat;
   assign thermStatus           = s_reg.tStat;
endmodule : maec_alert_ctrl
`default_nettype wire

/* sim/maec_alert_monitor.sv */
// Port checker for the alert enable and configuration block
`timescale 1ns/1ps
`default_nettype none
module maec_alert_monitor
   import maec_pkg::*;
(
   input wire logic                   mclk,
   input wire logic                   rst_n,
   input wire logic                   globalLock,
   input wire logic [7:0]             voltEvents,
   input wire logic [NUM_SENSORS-1:0] fanEvents,
   input wire logic [2:0]             thermEvents,
   input wire logic [7:0]             voltAck,
   input wire logic [7:0]             voltStatus,
   input wire logic [NUM_SENSORS-1:0] fanStatus,
   input wire logic [2:0]             thermStatus,
   input wire logic                   alert_n,
   input wire logic                   softResetPulse,
   input wire logic [7:0]             sensorDriveAssoc,
   input wire logic                   spinupShortenEnable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Nothing pending in any group
   sequence s_quiet;
      voltStatus == 8'h00 && fanStatus == 4'h0 && thermStatus == 3'h0;
   endsequence
   sequence s_quiet_two;
      s_quiet ##1 s_quiet;
   endsequence
   // A new status bit needs its event two cycles earlier
   a_volt_status_cause: assert property (
      (voltStatus & ~$past(voltStatus) & ~$past(voltEvents, 2)) == 8'h00)
      else $error("voltage status set without event");
   a_fan_status_cause: assert property (
      (fanStatus & ~$past(fanStatus) & ~$past(fanEvents, 2)) == 4'h0)
      else $error("fan status set without event");
   a_therm_status_cause: assert property (
      (thermStatus & ~$past(thermStatus) & ~$past(thermEvents, 2)) == 3'h0)
      else $error("thermal status set without event");
   // Sticky: only ack or soft reset may drop a voltage status bit
   a_status_sticky: assert property (
      softResetPulse || $past(softResetPulse) || $past(softResetPulse, 2) ||
      (($past(voltStatus) & ~voltStatus & ~($past(voltAck) | $past(voltAck, 2))) == 8'h00))
      else $error("voltage status dropped without ack");
   // Alert and status leave the same flop bank on the same edge
   a_alert_cause: assert property (!alert_n |->
      (voltStatus != 8'h00 || fanStatus != 4'h0 || thermStatus != 3'h0))
      else $error("alert low with nothing pending");
   a_alert_release: assert property (s_quiet_two |-> alert_n)
      else $error("alert held with nothing pending");
   a_soft_single: assert property (softResetPulse |=> !softResetPulse)
      else $error("soft reset pulse longer than one cycle");
   a_soft_restore: assert property (softResetPulse |-> ##[0:2]
      (sensorDriveAssoc == 8'ha4 && spinupShortenEnable))
      else $error("soft reset left registers changed");
   // Hazard: a pulse launched just before lock may still land
   a_lock_freeze: assert property (globalLock && $past(globalLock) &&
      !softResetPulse && !$past(softResetPulse) |->
      $stable(sensorDriveAssoc) && $stable(spinupShortenEnable))
      else $error("register changed under lock");
endmodule : maec_alert_monitor
bind maec_alert_ctrl maec_alert_monitor i_maec_alert_monitor (.mclk, .rst_n,
   .globalLock, .voltEvents, .fanEvents, .thermEvents, .voltAck, .voltStatus,
   .fanStatus, .thermStatus, .alert_n, .softResetPulse, .sensorDriveAssoc,
   .spinupShortenEnable);
`default_nettype wire

/* sim/monitor_alert_enable_config_tb_top.sv */
// Self-checking bench for the alert enable and configuration block
`timescale 1ns/1ps
`default_nettype none
module monitor_alert_enable_config_tb_top;
   import maec_pkg::*;
   logic        mclk, rst_n, regWrite, regRead, regRvalid, globalLock, thermalValid;
   logic        alert_n, sensor3PinAlertSelect, drive2PinAlertSelect;
   logic        spinupShortenEnable, softResetPulse;
   logic [7:0]  regAddr, regWdata, regRdata, voltEvents, voltAck, voltStatus;
   logic [7:0]  sensorDriveAssoc;
   logic [3:0]  fanEvents, fanAck, fanStatus;
   logic [2:0]  thermEvents, thermAck, thermStatus, driveEnabled;
   logic [23:0] driveDuty;
   logic [63:0] sensorMin;
   int          failCount = 0, compares = 0, cycles = 0, softSeen = 0;
   logic [7:0]  offs [6] = '{8'h7c, 8'h7e, 8'h7f, 8'h80, 8'h81, 8'h82};
   logic [7:0]  dflt [6] = '{8'h40, 8'hec, 8'h10, 8'h1e, 8'ha4, 8'h0e};
   logic [7:0]  full [6] = '{8'hff, 8'hed, 8'h00, 8'h1f, 8'h62, 8'h0f};

   maec_alert_ctrl i_maec_alert_ctrl (.mclk, .rst_n, .regWrite, .regRead, .regAddr,
      .regWdata, .regRdata, .regRvalid, .globalLock, .thermalValid, .voltEvents,
      .fanEvents, .thermEvents, .driveDuty, .driveEnabled, .sensorMin, .voltAck,
      .fanAck, .thermAck, .voltStatus, .fanStatus, .thermStatus, .alert_n,
      .sensor3PinAlertSelect, .drive2PinAlertSelect, .spinupShortenEnable,
      .sensorDriveAssoc, .softResetPulse);

   // Free-running 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Hang guard, soft reset pulse counter
   always @(posedge mclk) begin
      cycles++;
      if (softResetPulse === 1'b1) softSeen++;
      if (cycles == 3000) begin
         failCount++;
         report_and_stop();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      {regWrite, regAddr, regWdata} = {1'b1, a, d};
      @(negedge mclk);
      regWrite = 1'b0;
   endtask : wr

   // Read data and valid stand from the taking edge, checked at the next negedge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      {regRead, regAddr} = {1'b1, a};
      @(negedge mclk);
      regRead = 1'b0;
      chk("regRdata", regRdata, e);
      chk("regRvalid", {7'h0, regRvalid}, 8'h01);
   endtask : rd

   // One-cycle events, check status and alert, then ack everything
   task automatic evt(input logic [7:0] v, input logic [3:0] f, input logic [2:0] t,
                      input logic [7:0] ev, input logic [3:0] ef, input logic [2:0] et,
                      input logic ea);
      @(negedge mclk);
      {voltEvents, fanEvents, thermEvents} = {v, f, t};
      @(negedge mclk);
      {voltEvents, fanEvents, thermEvents} = '0;
      repeat (3) @(negedge mclk);
      chk("voltStatus", voltStatus, ev);
      chk("fanStatus", {4'h0, fanStatus}, {4'h0, ef});
      chk("thermStatus", {5'h0, thermStatus}, {5'h0, et});
      chk("alert_n", {7'h0, alert_n}, {7'h0, ea});
      {voltAck, fanAck, thermAck} = '1;
      @(negedge mclk);
      {voltAck, fanAck, thermAck} = '0;
      repeat (3) @(negedge mclk);
      chk("alert_n after ack", {7'h0, alert_n}, 8'h01);
   endtask : evt

   task report_and_stop;
      $display("Compares %0d, mismatches %0d", compares, failCount);
      if (failCount == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      {regWrite, regRead, globalLock, thermalValid, rst_n} = '0;
      {regAddr, regWdata, voltEvents, voltAck, fanEvents, fanAck} = '0;
      {thermEvents, thermAck} = '0;
      {driveDuty, driveEnabled, sensorMin} = {24'h808080, 3'h7, {4{16'h1000}}};
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++) rd(offs[i], dflt[i]);
      chk("assoc", sensorDriveAssoc, 8'ha4);
      rd(8'h83, 8'h00);
      thermalValid = 1'b1;
      rd(OFS_DEV_CFG, 8'h18);
      for (int i = 0; i < 6; i++) if (i != 2) begin
         // Association keeps every sensor on a real drive
         wr(offs[i], (i == 4) ? 8'h62 : 8'hff);
         rd(offs[i], full[i]);
      end
      // Bits five and six kept at their default zero
      wr(OFS_DEV_CFG, 8'h1f);
      rd(OFS_DEV_CFG, 8'h1b);
      chk("pins", {5'h0, sensor3PinAlertSelect, drive2PinAlertSelect, spinupShortenEnable}, 8'h07);
      wr(OFS_DEV_CFG, 8'h00);
      rd(OFS_DEV_CFG, 8'h08);
      chk("pins", {5'h0, sensor3PinAlertSelect, drive2PinAlertSelect, spinupShortenEnable}, 8'h00);
      wr(OFS_DEV_CFG, 8'h10);
      wr(OFS_ASSOC, 8'ha4);
      // Reserved and group bits must not let events through
      evt(8'hff, 4'hf, 3'h7, 8'hec, 4'hf, 3'h7, 1'b0);
      wr(OFS_VOLT_EN, 8'h24);
      evt(8'hec, 4'h0, 3'h0, 8'h24, 4'h0, 3'h0, 1'b1);
      wr(OFS_VOLT_EN, 8'hec);
      wr(OFS_FAN_EN, 8'h1e);
      wr(OFS_THERM_EN, 8'h0e);
      evt(8'hec, 4'hf, 3'h7, 8'hec, 4'hf, 3'h7, 1'b1);
      wr(OFS_THERM_EN, 8'h0f);
      evt(8'h00, 4'h0, 3'h1, 8'h00, 4'h0, 3'h1, 1'b0);
      wr(OFS_SPECIAL_FN, 8'h00);
      evt(8'h00, 4'h0, 3'h1, 8'h00, 4'h0, 3'h1, 1'b1);
      wr(OFS_SPECIAL_FN, 8'h04);
      wr(OFS_FAN_EN, 8'h1f);
      // Drive one off, drive two disabled, sensor three minimum all ones
      {driveDuty, driveEnabled} = {24'h808000, 3'h5};
      sensorMin[47:32] = 16'hffff;
      evt(8'h00, 4'hf, 3'h0, 8'h00, 4'h8, 3'h0, 1'b0);
      // Sensor one to drive three, sensor two to the idle drive one
      {driveEnabled, sensorMin} = {3'h7, {4{16'h1000}}};
      wr(OFS_ASSOC, 8'h62);
      evt(8'h00, 4'hf, 3'h0, 8'h00, 4'hd, 3'h0, 1'b0);
      globalLock = 1'b1;
      wr(OFS_ASSOC, 8'h00);
      wr(OFS_DEV_CFG, 8'h80);
      rd(OFS_ASSOC, 8'h62);
      chk("soft under lock", 8'(softSeen), 8'h00);
      {globalLock, thermalValid} = '0;
      @(negedge mclk);
      voltEvents = 8'h04;
      @(negedge mclk);
      voltEvents = 8'h00;
      repeat (3) @(negedge mclk);
      chk("pending", voltStatus, 8'h04);
      wr(OFS_DEV_CFG, 8'h80);
      repeat (3) @(negedge mclk);
      chk("soft pulses", 8'(softSeen), 8'h01);
      chk("status cleared", voltStatus, 8'h00);
      for (int i = 0; i < 6; i++) rd(offs[i], dflt[i]);
      report_and_stop();
   end
endmodule : monitor_alert_enable_config_tb_top
`default_nettype wire
